/* File: rtl/fgcd_pkg.sv */
package fgcd_pkg;
    // Register word addresses
    localparam logic [15:0] ADDR_ERR_COUNT    = 16'h8008;
    localparam logic [15:0] ADDR_ODD_NIB_CNT  = 16'h8010;
    localparam logic [15:0] ADDR_ODD_PRE_CNT  = 16'h8011;
    localparam logic [15:0] ADDR_FALSE_CAR    = 16'h8013;
    localparam logic [15:0] ADDR_GEN_ENABLE   = 16'h8020;
    localparam logic [15:0] ADDR_GEN_CTRL     = 16'h8021;
    localparam logic [15:0] ADDR_GEN_CONT     = 16'h8022;
    localparam logic [15:0] ADDR_GEN_IRQ_EN   = 16'h8023;
    localparam logic [15:0] ADDR_FRAME_LEN    = 16'h8025;
    localparam logic [15:0] ADDR_GAP_LEN      = 16'h8026;
    localparam logic [15:0] ADDR_BURST_HIGH   = 16'h8027;
    localparam logic [15:0] ADDR_BURST_LOW    = 16'h8028;
    localparam logic [15:0] ADDR_BURST_DONE   = 16'h8029;

    // Field positions
    localparam int RESTART_BIT = 3;
    localparam int DTYPE_MSB   = 2;

    // Reset values
    localparam logic [2:0]  RST_DATA_TYPE = 3'h1;
    localparam logic [15:0] RST_FRAME_LEN = 16'h006b;
    localparam logic [15:0] RST_GAP_LEN   = 16'h000c;
    localparam logic [15:0] RST_BURST_HI  = 16'h0000;
    localparam logic [15:0] RST_BURST_LO  = 16'h0100;

    // Frame overhead: 6 DA, 6 SA, 2 length, 4 FCS
    localparam logic [16:0] HDR_BYTES   = 17'h0000e;
    localparam logic [16:0] FCS_BYTES   = 17'h00004;
    localparam logic [16:0] FRAME_EXTRA = 17'h00012;

    // Data field selections
    typedef enum logic [2:0] {
        DT_NONE  = 3'b000,
        DT_RAND  = 3'b001,
        DT_ZERO  = 3'b010,
        DT_ONES  = 3'b011,
        DT_ALT55 = 3'b100,
        DT_DECR  = 3'b101
    } fgcd_dtype_t;

    localparam logic [7:0]  ALT_BYTE   = 8'h55;
    localparam logic [31:0] CRC_POLY   = 32'hedb88320;
    localparam logic [15:0] LFSR_SEED  = 16'hace1;
    localparam logic [15:0] LFSR_TAPS  = 16'hb400;
endpackage : fgcd_pkg

/* File: rtl/fgcd_gen_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Control and byte stream between register file and frame engine
interface fgcd_gen_if;
    logic        run;
    logic        start;
    logic [2:0]  dtype;
    logic        cont;
    logic [31:0] nfrm;
    logic [15:0] flen;
    logic [15:0] ifg;
    logic        tick;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        burst_done;

    modport ctrl   (output run, start, dtype, cont, nfrm, flen, ifg, tick,
                    input  tx_valid, tx_data, burst_done);
    modport engine (input  run, start, dtype, cont, nfrm, flen, ifg, tick,
                    output tx_valid, tx_data, burst_done);
endinterface : fgcd_gen_if
`default_nettype wire

/* File: rtl/fgcd_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module fgcd_engine #(
    parameter logic [47:0] DEST_ADDR = 48'hffffffffffff,
    parameter logic [47:0] SRC_ADDR  = 48'h020000000001  // Arbitrary value
) (
    input  wire logic    i_mclk,
    input  wire logic    i_reset,
    fgcd_gen_if.engine   g
);
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_FRAME = 2'b01,
        ENG_GAP   = 2'b10
    } fgcd_eng_t;

    fgcd_eng_t   state_ff;
    logic [16:0] pos_ff;
    logic [15:0] gap_ff;
    logic [31:0] remain_ff;
    logic        active_ff;
    logic        skip_ff;
    logic [31:0] crc_ff;
    logic [15:0] lfsr_ff;
    logic [7:0]  tx_data_ff;
    logic        tx_valid_ff;
    logic        done_ff;
    logic [7:0]  cur_byte;
    logic        may_begin;
    logic        last_byte;
    logic [16:0] data_end;

    // Bytewise reflected CRC-32 step
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ fgcd_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Header byte selection from a 48-bit address
    function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [16:0] idx);
        logic [47:0] s;
        s = a >> (8 * (5 - int'(idx)));
        return s[7:0];
    endfunction

    assign data_end  = fgcd_pkg::HDR_BYTES + {1'b0, g.flen};
    assign last_byte = (pos_ff == data_end + fgcd_pkg::FCS_BYTES - 17'h00001);
    // New frame only with a live burst and a data type
    // type none stops frames
    assign may_begin = active_ff && (g.dtype != fgcd_pkg::DT_NONE)
                       && (g.cont || remain_ff != 32'h0);

    // Byte at the current position of the frame
    // header, data, FCS
    always_comb begin
        logic [16:0] k;
        logic [31:0] fcs;
        k = pos_ff - data_end;
        fcs = ~crc_ff >> (8 * int'(k[1:0]));
        cur_byte = 8'h00;
        if (pos_ff < 17'h00006) begin
            cur_byte = addr_byte(DEST_ADDR, pos_ff);
        end else if (pos_ff < 17'h0000c) begin
            cur_byte = addr_byte(SRC_ADDR, pos_ff - 17'h00006);
        end else if (pos_ff == 17'h0000c) begin
            cur_byte = g.flen[15:8];
        end else if (pos_ff == 17'h0000d) begin
            cur_byte = g.flen[7:0];
        end else if (pos_ff < data_end) begin
            case (g.dtype)
                fgcd_pkg::DT_RAND:  cur_byte = lfsr_ff[7:0];
                fgcd_pkg::DT_ONES:  cur_byte = 8'hff;
                fgcd_pkg::DT_ALT55: cur_byte = fgcd_pkg::ALT_BYTE;
                fgcd_pkg::DT_DECR:  cur_byte = 8'hff - pos_ff[7:0] + 8'h0e;
                default:            cur_byte = 8'h00;
            endcase
        end else begin
            cur_byte = fcs[7:0];
        end
    end

    // Frame and gap sequencing, one step per byte slot
    always_ff @(posedge i_mclk) begin
        if (i_reset || !g.run) begin
            state_ff <= ENG_IDLE;
            pos_ff   <= 17'h00000;
            gap_ff   <= 16'h0000;
        end else if (g.tick) begin
            case (state_ff)
                ENG_IDLE: begin
                    if (may_begin) begin
                        state_ff <= ENG_FRAME;
                    end
                    pos_ff <= 17'h00000;
                end
                ENG_FRAME: begin
                    pos_ff <= pos_ff + 17'h00001;
                    if (last_byte) begin
                        state_ff <= ENG_GAP;
                        gap_ff   <= 16'h0001;
                    end
                end
                ENG_GAP: begin
                    gap_ff <= gap_ff + 16'h0001;
                    pos_ff <= 17'h00000;
                    if (gap_ff >= g.ifg) begin
                        state_ff <= may_begin ? ENG_FRAME : ENG_IDLE;
                    end
                end
                default: state_ff <= ENG_IDLE;
            endcase
        end
    end

    // Burst accounting; restart during a frame lets that frame go uncounted
    always_ff @(posedge i_mclk) begin
        if (i_reset || !g.run) begin
            active_ff <= 1'b0;
            remain_ff <= 32'h0;
            skip_ff   <= 1'b0;
            done_ff   <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (g.start) begin
                remain_ff <= g.nfrm;
                skip_ff   <= (state_ff == ENG_FRAME);
                active_ff <= g.cont || (g.nfrm != 32'h0);
                done_ff   <= !g.cont && (g.nfrm == 32'h0);
            end else if (g.tick && state_ff == ENG_FRAME && last_byte) begin
                if (skip_ff) begin
                    skip_ff <= 1'b0;
                end else if (!g.cont) begin
                    remain_ff <= remain_ff - 32'h1;
                    if (remain_ff == 32'h1) begin
                        active_ff <= 1'b0;
                        done_ff   <= 1'b1;
                    end
                end
            end
        end
    end

    // Output byte, FCS accumulation and random source
    always_ff @(posedge i_mclk) begin
        if (i_reset || !g.run) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff  <= 8'h00;
            crc_ff      <= 32'hffffffff;
            lfsr_ff     <= fgcd_pkg::LFSR_SEED;
        end else if (g.tick) begin
            tx_valid_ff <= (state_ff == ENG_FRAME);
            tx_data_ff  <= (state_ff == ENG_FRAME) ? cur_byte : 8'h00;
            if (state_ff != ENG_FRAME) begin
                crc_ff <= 32'hffffffff;
            end else if (pos_ff < data_end) begin
                crc_ff <= crc_step(crc_ff, cur_byte);
            end
            if (state_ff == ENG_FRAME && pos_ff >= fgcd_pkg::HDR_BYTES && pos_ff < data_end) begin
                lfsr_ff <= lfsr_ff[0] ? ((lfsr_ff >> 1) ^ fgcd_pkg::LFSR_TAPS) : (lfsr_ff >> 1);
            end
        end
    end

    assign g.tx_valid   = tx_valid_ff;
    assign g.tx_data    = tx_data_ff;
    assign g.burst_done = done_ff;
endmodule : fgcd_engine
`default_nettype wire

/* File: rtl/fgcd_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fgcd_top (
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    output logic             o_reg_rvalid,
    input  wire logic        i_odd_nibble_evt,
    input  wire logic        i_odd_preamble_evt,
    input  wire logic        i_bad_delim_evt,
    input  wire logic        i_byte_tick,
    input  wire logic        i_mac_tx_en,
    input  wire logic [7:0]  i_mac_tx_data,
    output logic             o_tx_en,
    output logic      [7:0]  o_tx_data,
    output logic             o_gen_irq_evt
);
    fgcd_gen_if gen ();

    logic        gen_on_ff;
    logic [2:0]  data_type_ff;
    logic        cont_on_ff;
    logic        irq_on_ff;
    logic [15:0] frame_len_ff;
    logic [15:0] gap_len_ff;
    logic [15:0] burst_hi_ff;
    logic [15:0] burst_lo_ff;
    logic        start_ff;
    logic        done_flag_ff;
    logic [15:0] odd_nib_live_ff;
    logic [15:0] odd_pre_live_ff;
    logic [15:0] false_car_live_ff;
    logic [15:0] odd_nib_lat_ff;
    logic [15:0] odd_pre_lat_ff;
    logic [15:0] false_car_lat_ff;
    logic [15:0] rdata_ff;
    logic        rvalid_ff;
    logic        tx_en_ff;
    logic [7:0]  tx_data_ff;
    logic        irq_ff;
    logic [15:0] nxt_rdata;
    logic        wr_on;
    logic        wr_ctrl;
    logic        rd_done;
    logic        rd_err;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
        return a == reg_addr;
    endfunction

    assign wr_on   = i_reg_wr && hit(i_reg_addr, fgcd_pkg::ADDR_GEN_ENABLE);
    assign wr_ctrl = i_reg_wr && hit(i_reg_addr, fgcd_pkg::ADDR_GEN_CTRL);
    assign rd_done = i_reg_rd && hit(i_reg_addr, fgcd_pkg::ADDR_BURST_DONE);
    assign rd_err  = i_reg_rd && hit(i_reg_addr, fgcd_pkg::ADDR_ERR_COUNT);

    // Writable generator configuration
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            gen_on_ff    <= 1'b0;
            data_type_ff <= fgcd_pkg::RST_DATA_TYPE;
            cont_on_ff   <= 1'b0;
            irq_on_ff    <= 1'b0;
            frame_len_ff <= fgcd_pkg::RST_FRAME_LEN;
            gap_len_ff   <= fgcd_pkg::RST_GAP_LEN;
            burst_hi_ff  <= fgcd_pkg::RST_BURST_HI;
            burst_lo_ff  <= fgcd_pkg::RST_BURST_LO;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                fgcd_pkg::ADDR_GEN_ENABLE: gen_on_ff    <= i_reg_wdata[0];
                fgcd_pkg::ADDR_GEN_CTRL:   data_type_ff <= i_reg_wdata[fgcd_pkg::DTYPE_MSB:0];
                fgcd_pkg::ADDR_GEN_CONT:   cont_on_ff   <= i_reg_wdata[0];
                fgcd_pkg::ADDR_GEN_IRQ_EN: irq_on_ff    <= i_reg_wdata[0];
                fgcd_pkg::ADDR_FRAME_LEN:  frame_len_ff <= i_reg_wdata;
                fgcd_pkg::ADDR_GAP_LEN:    gap_len_ff   <= i_reg_wdata;
                fgcd_pkg::ADDR_BURST_HIGH: burst_hi_ff  <= i_reg_wdata;
                fgcd_pkg::ADDR_BURST_LOW:  burst_lo_ff  <= i_reg_wdata;
                default:                   ;
            endcase
        end
    end

    // Start on enable rise or restart while on; restart reads back 0
    // self-clearing restart
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= (wr_on && i_reg_wdata[0] && !gen_on_ff)
                        || (wr_ctrl && i_reg_wdata[fgcd_pkg::RESTART_BIT] && gen_on_ff);
        end
    end

    assign gen.run   = gen_on_ff;
    assign gen.start = start_ff;
    assign gen.dtype = data_type_ff;
    assign gen.cont  = cont_on_ff;
    assign gen.nfrm  = {burst_hi_ff, burst_lo_ff};
    assign gen.flen  = frame_len_ff;
    assign gen.ifg   = gap_len_ff;
    assign gen.tick  = i_byte_tick;

    fgcd_engine u_engine (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .g       (gen.engine)
    );

    // Sticky completion flag; a completion in the read cycle survives
    // set wins over read
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            done_flag_ff <= 1'b0;
        end else if (gen.burst_done) begin
            done_flag_ff <= 1'b1;
        end else if (rd_done) begin
            done_flag_ff <= 1'b0;
        end
    end

    // Completion event toward the subsystem status flag
    // gated by interrupt enable
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= gen.burst_done && irq_on_ff;
        end
    end

    // Live checker counters, wrapping at 16 bits
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            odd_nib_live_ff   <= 16'h0000;
            odd_pre_live_ff   <= 16'h0000;
            false_car_live_ff <= 16'h0000;
        end else begin
            if (i_odd_nibble_evt) begin
                odd_nib_live_ff <= odd_nib_live_ff + 16'h0001;
            end
            if (i_odd_preamble_evt) begin
                odd_pre_live_ff <= odd_pre_live_ff + 16'h0001;
            end
            if (i_bad_delim_evt) begin
                false_car_live_ff <= false_car_live_ff + 16'h0001;
            end
        end
    end

    // Snapshot on error counter read; same-cycle events show next time
    // common capture
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            odd_nib_lat_ff   <= 16'h0000;
            odd_pre_lat_ff   <= 16'h0000;
            false_car_lat_ff <= 16'h0000;
        end else if (rd_err) begin
            odd_nib_lat_ff   <= odd_nib_live_ff;
            odd_pre_lat_ff   <= odd_pre_live_ff;
            false_car_lat_ff <= false_car_live_ff;
        end
    end

    // Read mux; the latched counters have no write path
    // read-only latched counters
    always_comb begin
        nxt_rdata = 16'h0000;
        case (i_reg_addr)
            fgcd_pkg::ADDR_ODD_NIB_CNT: nxt_rdata = odd_nib_lat_ff;
            fgcd_pkg::ADDR_ODD_PRE_CNT: nxt_rdata = odd_pre_lat_ff;
            fgcd_pkg::ADDR_FALSE_CAR:   nxt_rdata = false_car_lat_ff;
            fgcd_pkg::ADDR_GEN_ENABLE:  nxt_rdata = {15'h0000, gen_on_ff};
            fgcd_pkg::ADDR_GEN_CTRL:    nxt_rdata = {13'h0000, data_type_ff};
            fgcd_pkg::ADDR_GEN_CONT:    nxt_rdata = {15'h0000, cont_on_ff};
            fgcd_pkg::ADDR_GEN_IRQ_EN:  nxt_rdata = {15'h0000, irq_on_ff};
            fgcd_pkg::ADDR_FRAME_LEN:   nxt_rdata = frame_len_ff;
            fgcd_pkg::ADDR_GAP_LEN:     nxt_rdata = gap_len_ff;
            fgcd_pkg::ADDR_BURST_HIGH:  nxt_rdata = burst_hi_ff;
            fgcd_pkg::ADDR_BURST_LOW:   nxt_rdata = burst_lo_ff;
            fgcd_pkg::ADDR_BURST_DONE:  nxt_rdata = {15'h0000, done_flag_ff};
            default:                    nxt_rdata = 16'h0000;
        endcase
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdata_ff  <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= i_reg_rd;
            if (i_reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // Transmit source select; switching mid-frame truncates that frame
    // generator replaces MAC data
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            tx_en_ff   <= 1'b0;
            tx_data_ff <= 8'h00;
        end else if (gen_on_ff) begin
            tx_en_ff   <= gen.tx_valid;
            tx_data_ff <= gen.tx_data;
        end else begin
            tx_en_ff   <= i_mac_tx_en;
            tx_data_ff <= i_mac_tx_data;
        end
    end

    assign o_reg_rdata   = rdata_ff;
    assign o_reg_rvalid  = rvalid_ff;
    assign o_tx_en       = tx_en_ff;
    assign o_tx_data     = tx_data_ff;
    assign o_gen_irq_evt = irq_ff;
endmodule : fgcd_top
`default_nettype wire

/* File: sim/fgcd_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fgcd_phy_model (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic       i_slow,
    input  wire logic       i_tx_en,
    input  wire logic [7:0] i_tx_data,
    output logic            o_byte_tick,
    output int              o_frames,
    output int              o_last_len,
    output logic [7:0]      o_buf [64]
);
    int         div_ff;
    int         idx_ff;
    logic [2:0] dly_ff;
    logic       in_frm_ff;

    // Byte slots every 2 cycles, or every 5 when slow; >= keeps a mode switch safe
    always_ff @(posedge i_mclk) begin
        if (i_reset || div_ff >= (i_slow ? 4 : 1)) begin
            div_ff <= 0;
        end else begin
            div_ff <= div_ff + 1;
        end
    end
    assign o_byte_tick = (div_ff == 0) && !i_reset;

    // Sample three edges after each slot, past the pipeline
    always_ff @(posedge i_mclk) begin
        dly_ff <= i_reset ? 3'h0 : {dly_ff[1:0], o_byte_tick};
        if (i_reset) begin
            in_frm_ff  <= 1'b0;
            idx_ff     <= 0;
            o_frames   <= 0;
            o_last_len <= 0;
        end else if (dly_ff[2] && i_tx_en) begin
            o_buf[idx_ff[5:0]] <= i_tx_data;
            idx_ff             <= idx_ff + 1;
            in_frm_ff          <= 1'b1;
        end else if (dly_ff[2] && in_frm_ff) begin
            in_frm_ff  <= 1'b0;
            o_frames   <= o_frames + 1;
            o_last_len <= idx_ff;
            idx_ff     <= 0;
        end
    end
endmodule // fgcd_phy_model
`default_nettype wire

/* File: sim/fgcd_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fgcd_chk (
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_wdata,
    input  wire logic [15:0] o_reg_rdata,
    input  wire logic        o_reg_rvalid,
    input  wire logic        i_mac_tx_en,
    input  wire logic [7:0]  i_mac_tx_data,
    input  wire logic        o_tx_en,
    input  wire logic [7:0]  o_tx_data,
    input  wire logic        o_gen_irq_evt
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    logic on_ff;
    logic irq_on_ff;
    logic cont_ff;

    // Shadow control bits
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            on_ff     <= 1'b0;
            irq_on_ff <= 1'b0;
            cont_ff   <= 1'b0;
        end else if (i_reg_wr) begin
            if (i_reg_addr == fgcd_pkg::ADDR_GEN_ENABLE) on_ff <= i_reg_wdata[0];
            if (i_reg_addr == fgcd_pkg::ADDR_GEN_IRQ_EN) irq_on_ff <= i_reg_wdata[0];
            if (i_reg_addr == fgcd_pkg::ADDR_GEN_CONT) cont_ff <= i_reg_wdata[0];
        end
    end

    property p_rd_answer;
        i_reg_rd |=> o_reg_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_no_stray;
        !i_reg_rd |=> !o_reg_rvalid;
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("stray read answer");
    property p_rdata_hold;
        !i_reg_rd |=> $stable(o_reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_mac_pass;
        !$past(i_reset) && !$past(on_ff) |-> o_tx_en == $past(i_mac_tx_en)
            && (!o_tx_en || o_tx_data == $past(i_mac_tx_data));
    endproperty
    a_mac_pass: assert property (p_mac_pass) else $error("MAC stream not passed");
    property p_irq_cause;
        o_gen_irq_evt |-> $past(irq_on_ff) ##1 !o_gen_irq_evt;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("bad interrupt pulse");
    property p_irq_cont;
        $past(cont_ff, 2) |-> !o_gen_irq_evt;
    endproperty
    a_irq_cont: assert property (p_irq_cont) else $error("irq in continuous mode");
    property p_restart_rd;
        i_reg_rd && i_reg_addr == fgcd_pkg::ADDR_GEN_CTRL |=> o_reg_rdata[15:3] == 13'h0;
    endproperty
    a_restart_rd: assert property (p_restart_rd) else $error("restart bit not clear");
    property p_en_rd;
        i_reg_rd && i_reg_addr == fgcd_pkg::ADDR_GEN_ENABLE
            |=> o_reg_rdata == {15'h0, $past(on_ff)};
    endproperty
    a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
endmodule // fgcd_chk
bind fgcd_top fgcd_chk fgcd_chk_inst (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_mac_tx_en(i_mac_tx_en), .i_mac_tx_data(i_mac_tx_data), .o_tx_en(o_tx_en),
    .o_tx_data(o_tx_data), .o_gen_irq_evt(o_gen_irq_evt));
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        mclk;
    logic        reset;
    logic [15:0] reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic [2:0]  evt;
    logic        byte_tick;
    logic        mac_en;
    logic [7:0]  mac_data = 8'h00;
    logic        tx_en;
    logic [7:0]  tx_data;
    logic        irq;
    logic        slow;
    logic [7:0]  fbuf [64];
    logic [15:0] got;
    int          frames;
    int          last_len;
    int          errors = 0;
    int          compares = 0;
    int          irqs = 0;
    int          f0, i0, flen, n1, n2, n3;
    logic [15:0] ra [13] = '{16'h8010, 16'h8011, 16'h8013, 16'h8020, 16'h8021, 16'h8022,
        16'h8023, 16'h8025, 16'h8026, 16'h8027, 16'h8028, 16'h8029, 16'h8030};
    logic [15:0] rv [13] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0, 16'h0, 16'h6b,
        16'hc, 16'h0, 16'h100, 16'h0, 16'h0};

    fgcd_top fgcd_top_inst (.i_mclk(mclk), .i_reset(reset), .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .i_odd_nibble_evt(evt[0]),
        .i_odd_preamble_evt(evt[1]), .i_bad_delim_evt(evt[2]), .i_byte_tick(byte_tick),
        .i_mac_tx_en(mac_en), .i_mac_tx_data(mac_data), .o_tx_en(tx_en),
        .o_tx_data(tx_data), .o_gen_irq_evt(irq));
    fgcd_phy_model fgcd_phy_model_inst (.i_mclk(mclk), .i_reset(reset), .i_slow(slow),
        .i_tx_en(tx_en), .i_tx_data(tx_data), .o_byte_tick(byte_tick),
        .o_frames(frames), .o_last_len(last_len), .o_buf(fbuf));

    // Clock, 5 ns period
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Random MAC bytes, which must never leak while the generator runs
    always @(negedge mclk) mac_data <= 8'($urandom);
    always @(negedge mclk) if (irq === 1'b1) irqs <= irqs + 1;

    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Idle cycle between accesses
    task automatic wr(input logic [15:0] a, d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        got = reg_rdata;
    endtask
    task automatic pulse(input int a, b, c);
        for (int k = 0; k < 32; k++) begin
            @(negedge mclk);
            evt = {k < c, k < b, k < a};
        end
    endtask
    task automatic wait_frames(input int n);
        for (int k = 0; k < 20000 && frames < n; k++) @(negedge mclk);
        repeat (400) @(negedge mclk);
    endtask
    function automatic logic [7:0] exp_byte(input logic [2:0] d, input int k);
        case (d)
            fgcd_pkg::DT_ZERO:  return 8'h00;
            fgcd_pkg::DT_ONES:  return 8'hff;
            fgcd_pkg::DT_ALT55: return 8'h55;
            default:            return 8'hff - 8'(k);
        endcase
    endfunction
    // Enable, noting where the counts stood
    task automatic start_gen;
        f0 = frames;
        i0 = irqs;
        wr(fgcd_pkg::ADDR_GEN_ENABLE, 16'h0001);
        mac_en = 1'b1;
    endtask
    task automatic stop_gen;
        mac_en = 1'b0;
        wr(fgcd_pkg::ADDR_GEN_ENABLE, 16'h0000);
    endtask
    task automatic run_burst(input logic [2:0] d);
        flen = $urandom_range(20, 4);
        wr(fgcd_pkg::ADDR_FRAME_LEN, 16'(flen));
        wr(fgcd_pkg::ADDR_GAP_LEN, 16'($urandom_range(3, 0)));
        wr(fgcd_pkg::ADDR_GEN_CTRL, {13'h0, d});
        slow = 1'($urandom);
        start_gen();
        wait_frames(f0 + 3);
        chk(frames - f0, 3);
        chk(irqs - i0, 1);
        chk(last_len, flen + 18);
        chk({fbuf[0], fbuf[12], fbuf[13]}, {8'hff, 16'(flen)});
        for (int k = 0; k < flen; k++) if (d != 3'h1) chk(fbuf[14 + k], exp_byte(d, k));
        rd(fgcd_pkg::ADDR_BURST_DONE);
        chk(got, 16'h0001);
        rd(fgcd_pkg::ADDR_BURST_DONE);
        chk(got, 16'h0000);
        stop_gen();
    endtask
    task automatic tally_and_finish;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog, far past the ~7000-cycle run
    initial begin
        #400000;
        errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h2e57a19c));
        {reg_addr, reg_wr, reg_rd, reg_wdata, evt, mac_en, slow} = '0;
        reset = 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        for (int k = 0; k < 4; k++) wr(16'h8010 + 16'(k), 16'($urandom));
        foreach (ra[k]) begin
            rd(ra[k]);
            chk(got, rv[k]);
        end
        n1 = $urandom_range(30, 1);
        n2 = $urandom_range(30, 1);
        n3 = $urandom_range(30, 1);
        pulse(n1, n2, n3);
        rd(fgcd_pkg::ADDR_ODD_NIB_CNT);
        chk(got, 16'h0000);
        rd(fgcd_pkg::ADDR_ERR_COUNT);
        pulse(1, 1, 1);
        rd(fgcd_pkg::ADDR_ODD_NIB_CNT);
        chk(got, 16'(n1));
        rd(fgcd_pkg::ADDR_ODD_PRE_CNT);
        chk(got, 16'(n2));
        rd(fgcd_pkg::ADDR_FALSE_CAR);
        chk(got, 16'(n3));
        rd(fgcd_pkg::ADDR_ERR_COUNT);
        rd(fgcd_pkg::ADDR_FALSE_CAR);
        chk(got, 16'(n3 + 1));
        // MAC stream while off, judged by the checker
        repeat (60) @(negedge mclk) mac_en = 1'($urandom);
        mac_en = 1'b0;
        wr(fgcd_pkg::ADDR_BURST_LOW, 16'h0003);
        wr(fgcd_pkg::ADDR_GEN_IRQ_EN, 16'h0001);
        for (int d = 1; d <= 5; d++) run_burst(3'(d));
        wr(fgcd_pkg::ADDR_GEN_CONT, 16'h0001);
        start_gen();
        wait_frames(f0 + 5);
        chk(irqs - i0, 0);
        wr(fgcd_pkg::ADDR_GEN_CTRL, 16'h0000);
        f0 = frames;
        wait_frames(0);
        chk(32'(frames - f0 <= 1), 1);
        f0 = frames;
        wait_frames(0);
        chk(frames - f0, 0);
        stop_gen();
        wr(fgcd_pkg::ADDR_GEN_CONT, 16'h0000);
        wr(fgcd_pkg::ADDR_GEN_CTRL, 16'h0005);
        wr(fgcd_pkg::ADDR_BURST_LOW, 16'h0002);
        start_gen();
        for (int k = 0; k < 300 && tx_en !== 1'b1; k++) @(negedge mclk);
        wr(fgcd_pkg::ADDR_GEN_CTRL, 16'h000d);
        wait_frames(f0 + 3);
        chk(frames - f0, 3);
        chk(irqs - i0, 1);
        rd(fgcd_pkg::ADDR_GEN_CTRL);
        chk(got, 16'h0005);
        stop_gen();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
